// [tb/rtc_alarm_periodic_control_bench.sv]
/*
 * self-checking bench for the calendar clock core: reset values, alarm
 * matching and flag handling, half-minute rounding, periodic intervals.
 * assumes rtc_pkg and rtc_core are compiled first; the count clock pin is
 * driven much faster than 32.768 kHz so periodic intervals stay short.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("ERROR at %0t: mismatch got %h exp %h", $time, got, exp); \
        end \
    end

module rtc_alarm_periodic_control_bench import rtc_pkg::*;;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    logic count_clk_pin;
    logic ctrl1_wr = 1'b0, ctrl2_wr = 1'b0, time_wr = 1'b0, alarm_wr = 1'b0;
    logic [7:0] ctrl1_wdata = 8'h00, ctrl2_wdata = 8'h00;
    logic [7:0] time_wdata = 8'h00, alarm_wdata = 8'h00;
    logic [2:0] time_sel = 3'h0, alarm_sel = 3'h0;
    logic [7:0] clock_control_one, clock_control_two, clock_control_three;
    logic [7:0] seconds_counter, minutes_counter, hours_counter, weekday_counter;
    logic [7:0] date_counter, month_counter, year_counter;
    logic alarm_irq, periodic_irq;
    logic tick_on = 1'b0;
    logic [2:0] ph = 3'h0;
    int cyc = 0;
    int error_cnt = 0;
    int cmp_count = 0;

    // ----------------------------------------------------------------
    // clock, count clock and device
    // ----------------------------------------------------------------
    // system clock, 8 ns period
    always #4 clock = ~clock;

    // count clock pin, one rising edge every 8 cycles while enabled
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (tick_on) begin
            ph <= ph + 3'h1;
        end
    end
    assign count_clk_pin = ph[2];

    rtc_core dut_u (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .count_clk_pin(count_clk_pin),
        .ctrl1_wr(ctrl1_wr), .ctrl1_wdata(ctrl1_wdata),
        .ctrl2_wr(ctrl2_wr), .ctrl2_wdata(ctrl2_wdata),
        .time_wr(time_wr), .time_sel(time_sel), .time_wdata(time_wdata),
        .alarm_wr(alarm_wr), .alarm_sel(alarm_sel), .alarm_wdata(alarm_wdata),
        .clock_control_one(clock_control_one), .clock_control_two(clock_control_two),
        .clock_control_three(clock_control_three), .seconds_counter(seconds_counter),
        .minutes_counter(minutes_counter), .hours_counter(hours_counter),
        .weekday_counter(weekday_counter), .date_counter(date_counter),
        .month_counter(month_counter), .year_counter(year_counter),
        .alarm_irq(alarm_irq), .periodic_irq(periodic_irq)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one-cycle write: 1 ctrl1, 2 ctrl2, 3 calendar, 4 alarm; flags settle after
    task automatic wr(input int k, input logic [2:0] s, input logic [7:0] d);
        @(posedge clock);
        ctrl1_wdata <= d;
        ctrl2_wdata <= d;
        time_wdata <= d;
        alarm_wdata <= d;
        time_sel <= s;
        alarm_sel <= s;
        ctrl1_wr <= (k == 1);
        ctrl2_wr <= (k == 2);
        time_wr <= (k == 3);
        alarm_wr <= (k == 4);
        @(posedge clock);
        ctrl1_wr <= 1'b0;
        ctrl2_wr <= 1'b0;
        time_wr <= 1'b0;
        alarm_wr <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    // bounded wait for the periodic flag, returns the cycle it was seen
    task automatic wait_flag(output int c);
        for (int i = 0; i < 40000 && clock_control_two[7] !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        c = cyc;
        if (clock_control_two[7] !== 1'b1) begin
            error_cnt++;
            $display("ERROR at %0t: periodic flag never set", $time);
            give_verdict();
        end
    endtask

    // flag must stay clear over n cycles
    task automatic no_flag(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
            seen = seen | (clock_control_two[7] === 1'b1);
        end
        `CHECK(seen, 1'b0)
    endtask

    // minutes to year as one word, minutes in the low byte
    function automatic logic [47:0] now_time();
        return {year_counter, month_counter, date_counter, weekday_counter, hours_counter,
                minutes_counter};
    endfunction

    // reads the time until two reads agree, so a carry in between is not taken
    task automatic read_time(output logic [47:0] t);
        logic [47:0] again;
        again = '1;
        t = '0;
        for (int i = 0; i < 4 && t !== again; i++) begin
            t = now_time();
            @(posedge clock);
            #1;
            again = now_time();
        end
        if (t !== again) begin
            error_cnt++;
            $display("ERROR at %0t: time read never settled", $time);
            give_verdict();
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        `CHECK(clock_control_one, 8'h00)
        `CHECK(clock_control_two, C2_RESET)
        `CHECK(clock_control_three, 8'h00)
        `CHECK(seconds_counter, ZERO_RESET)
        `CHECK({date_counter, month_counter}, {ONE_RESET, ONE_RESET})
        `CHECK({alarm_irq, periodic_irq}, 2'b00)
        $display("test reset done");
    endtask

    task automatic t_alarm;
        wr(2, 3'h0, 8'h08);
        // every calendar and alarm byte to a known value, counting stopped
        for (int f = 0; f < NUM_FIELDS; f++) begin
            wr(3, f[2:0], (f == F_DATE || f == F_MON) ? ONE_RESET : ZERO_RESET);
            wr(4, f[2:0], ALARM_RESET);
        end
        wr(4, F_SEC, 8'h85);
        wr(4, F_MIN, 8'h00);
        wr(3, F_SEC, 8'h04);
        `CHECK(clock_control_one[0], 1'b0)
        wr(3, F_SEC, 8'h05);
        `CHECK(clock_control_one[0], 1'b1)
        `CHECK(alarm_irq, 1'b0)
        wr(1, 3'h0, 8'h09);
        `CHECK(clock_control_one, 8'h09)
        `CHECK(alarm_irq, 1'b1)
        wr(1, 3'h0, 8'h08);
        `CHECK(clock_control_one, 8'h08)
        `CHECK(alarm_irq, 1'b0)
        wr(3, F_SEC, 8'h00);
        wr(4, F_MIN, 8'h83);
        wr(4, F_YEAR, 8'h80);
        `CHECK(clock_control_three, 8'h80)
        wr(3, F_SEC, 8'h05);
        `CHECK(clock_control_one[0], 1'b0)
        wr(3, F_MIN, 8'h03);
        `CHECK(clock_control_one[0], 1'b1)
        `CHECK(alarm_irq, 1'b1)
        wr(4, F_YEAR, 8'h81);
        wr(1, 3'h0, 8'h08);
        `CHECK(clock_control_one[0], 1'b0)
        wr(3, F_YEAR, 8'h01);
        `CHECK(clock_control_one[0], 1'b1)
        $display("test alarm done");
    endtask

    task automatic t_round;
        logic [47:0] t;
        wr(3, F_SEC, 8'h1d);
        wr(3, F_MIN, 8'h3b);
        wr(2, 3'h0, 8'h0c);
        `CHECK({seconds_counter, minutes_counter}, {8'h00, 8'h3b})
        `CHECK(clock_control_two, 8'h08)
        wr(3, F_SEC, 8'h1e);
        wr(3, F_HOUR, 8'h05);
        wr(3, F_WDAY, 8'h03);
        // stop, read back and rewrite minutes to year, then round
        wr(2, 3'h0, 8'h08);
        read_time(t);
        for (int f = 1; f < NUM_FIELDS; f++) begin
            wr(3, f[2:0], t[8*(f-1) +: 8]);
        end
        // field code 7 is ignored
        wr(3, 3'h7, 8'h2a);
        wr(2, 3'h0, 8'h0c);
        `CHECK({seconds_counter, minutes_counter, hours_counter}, 24'h000006)
        `CHECK({weekday_counter, date_counter, month_counter, year_counter}, 32'h03010101)
        // round up without a minute wrap
        wr(3, F_SEC, 8'h2d);
        wr(2, 3'h0, 8'h0c);
        `CHECK({seconds_counter, minutes_counter}, {8'h00, 8'h01})
        // writes ignored while the clock enable is low
        repeat (16) @(posedge clock);
        ce <= 1'b0;
        wr(3, F_SEC, 8'h11);
        `CHECK(seconds_counter, 8'h00)
        @(posedge clock);
        ce <= 1'b1;
        // counting restarts once rounding is over
        wr(2, 3'h0, 8'h09);
        `CHECK(clock_control_two, 8'h09)
        $display("test round done");
    endtask

    task automatic t_periodic;
        int c1;
        int c2;
        @(posedge clock);
        tick_on <= 1'b1;
        for (int s = 1; s <= 3; s++) begin
            wr(2, 3'h0, {1'b0, s[2:0], 4'ha});
            wait_flag(c1);
            `CHECK(periodic_irq, 1'b1)
            wr(2, 3'h0, {1'b0, s[2:0], 4'h8});
            `CHECK({clock_control_two[7], periodic_irq}, 2'b00)
            wait_flag(c2);
            `CHECK(c2 - c1, 8 << (5 + 2 * s))
        end
        wr(2, 3'h0, 8'h08);
        no_flag(2100);
        `CHECK(periodic_irq, 1'b0)
        wr(2, 3'h0, 8'h10);
        no_flag(2100);
        for (int s = 4; s <= 7; s++) begin
            wr(2, 3'h0, {1'b0, s[2:0], 4'h8});
            `CHECK(clock_control_two, {1'b0, s[2:0], 4'h8})
        end
        $display("test periodic done");
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    // reset for 5 cycles, then each scenario in turn
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        t_reset();
        t_alarm();
        t_round();
        t_periodic();
        give_verdict();
    end
endmodule // rtc_alarm_periodic_control_bench

`default_nettype wire

// [verilog/alarm_compare.sv]
/*
 * alarm comparator: each alarm byte whose compare enable is set must equal
 * its counter; at least one enabled field is needed for a match.
 * assumes counters and alarm bytes come from flops on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module alarm_compare
    import rtc_pkg::*;
#(
    parameter int FIELDS = NUM_FIELDS
) (
    input wire logic [FIELDS-1:0][7:0] alarm_value,
    input wire logic [FIELDS-1:0][7:0] counter_value,
    output logic match
);

    logic [FIELDS-1:0] field_ok;
    logic [FIELDS-1:0] field_on;

    // per-field compare, disabled fields always agree
    genvar g;
    generate
        for (g = 0; g < FIELDS; g++) begin : gen_field
            assign field_on[g] = alarm_value[g][ALARM_ENABLE_BIT];
            assign field_ok[g] = !field_on[g] ||
                (alarm_value[g][6:0] == counter_value[g][6:0]);
        end
    endgenerate

    // all enabled fields agree, and some field is enabled
    assign match = (&field_ok) && (|field_on);

endmodule // alarm_compare

`default_nettype wire

// [verilog/rtc_core.sv]
/*
 * calendar clock core: count-clock divider, calendar counters, alarm flag,
 * periodic flag and half-minute rounding, all controlled by plain ports.
 * assumes count_clk_pin is an asynchronous 32.768 kHz pin and write strobes
 * are one-cycle pulses on the system clock.
 */
// Behaviour
// - an alarm may use any combination of the seven time fields, only enabled ones compared.
// - the alarm flag is set when all enabled alarm fields equal the counters.
// - with the alarm interrupt enable set, an alarm match raises the alarm request.
// - writing 0 to the alarm flag clears it.
// - the periodic flag is set each time the selected interval elapses.
// - the periodic flag clears only when clock_control_two is written; taking the interrupt leaves it set.
// - select codes 000 none, then 1/256, 1/64, 1/16, 1/4, 1/2, 1 and 2 seconds.
// - a rounding write sends 29 s or less to zero, 30 s or more up a minute, resets the divider, reads 0.
// - with counting stopped the calendar holds while the divider runs unless the oscillator is off.
// - bit 7 of each alarm byte is its compare enable, the year included.
`timescale 1ns/1ps
`default_nettype none

module rtc_core
    import rtc_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic count_clk_pin,
    input wire logic ctrl1_wr,
    input wire logic [7:0] ctrl1_wdata,
    input wire logic ctrl2_wr,
    input wire logic [7:0] ctrl2_wdata,
    input wire logic time_wr,
    input wire logic [2:0] time_sel,
    input wire logic [7:0] time_wdata,
    input wire logic alarm_wr,
    input wire logic [2:0] alarm_sel,
    input wire logic [7:0] alarm_wdata,
    output logic [7:0] clock_control_one,
    output logic [7:0] clock_control_two,
    output logic [7:0] clock_control_three,
    output logic [7:0] seconds_counter,
    output logic [7:0] minutes_counter,
    output logic [7:0] hours_counter,
    output logic [7:0] weekday_counter,
    output logic [7:0] date_counter,
    output logic [7:0] month_counter,
    output logic [7:0] year_counter,
    output logic alarm_irq,
    output logic periodic_irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
        logic [7:0] d;
        d = 8'h1f;
        if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h0b) begin
            d = 8'h1e;
        end else if (mon == 8'h02) begin
            d = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        end
        return d;
    endfunction
    function automatic logic wrap_inc(input logic [7:0] v, input logic [7:0] top,
                                      input logic [7:0] base, output logic [7:0] nv);
        logic w;
        w = (v >= top);
        nv = w ? base : v + 8'h01;
        return w;
    endfunction

    // ----------------------------------------------------------------
    // count-clock synchroniser and tick
    // ----------------------------------------------------------------
    logic cc_meta_q, cc_sync_q, cc_prev_q;
    logic tick;
    // two flops, then an edge detect on the second
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cc_meta_q <= 1'b0;
            cc_sync_q <= 1'b0;
            cc_prev_q <= 1'b0;
        end else if (ce) begin
            cc_meta_q <= count_clk_pin;
            cc_sync_q <= cc_meta_q;
            cc_prev_q <= cc_sync_q;
        end
    end
    assign tick = cc_sync_q && !cc_prev_q;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    logic aie_q, aie_d, alarm_flag_q, alarm_flag_d;
    logic periodic_flag_q, periodic_flag_d, osc_run_q, osc_run_d, run_q, run_d;
    logic [2:0] sel_q, sel_d;
    logic [DIV_WIDTH-1:0] div_q, div_d;
    logic match, match_prev_q, match_rise, period_evt, sec_tick, half_minute_round, div_reset;
    logic [NUM_FIELDS-1:0][7:0] alarm_q, alarm_d, cal_q, cal_d;
    assign half_minute_round = ctrl2_wr && ctrl2_wdata[C2_ROUND_BIT];
    assign div_reset = ctrl2_wr && (ctrl2_wdata[C2_ROUND_BIT] || ctrl2_wdata[C2_DIV_RESET_BIT]);
    assign sec_tick = tick && osc_run_q && (div_q[SECOND_TAP-1:0] == '1);
    assign match_rise = match && !match_prev_q;
    // periodic event: the selected divider span wraps
    always_comb begin
        period_evt = 1'b0;
        if (tick && osc_run_q) begin
            unique case (sel_q)
                3'h0: period_evt = 1'b0;
                3'h1: period_evt = (div_q[6:0] == '1);
                3'h2: period_evt = (div_q[8:0] == '1);
                3'h3: period_evt = (div_q[10:0] == '1);
                3'h4: period_evt = (div_q[12:0] == '1);
                3'h5: period_evt = (div_q[13:0] == '1);
                3'h6: period_evt = (div_q[14:0] == '1);
                3'h7: period_evt = (div_q == '1);
            endcase
        end
    end
    // next values of control, flags and divider
    always_comb begin
        aie_d = aie_q;
        sel_d = sel_q;
        osc_run_d = osc_run_q;
        run_d = run_q;
        alarm_flag_d = alarm_flag_q;
        periodic_flag_d = periodic_flag_q;
        div_d = div_q;
        if (ctrl1_wr) begin
            aie_d = ctrl1_wdata[C1_ALARM_IRQ_ENABLE_BIT];
            if (!ctrl1_wdata[C1_ALARM_FLAG_BIT]) begin
                alarm_flag_d = 1'b0;
            end
        end
        if (match_rise) begin
            alarm_flag_d = 1'b1;
        end
        if (ctrl2_wr) begin
            sel_d = ctrl2_wdata[C2_SELECT_MSB:C2_SELECT_LSB];
            osc_run_d = ctrl2_wdata[C2_OSC_RUN_BIT];
            run_d = ctrl2_wdata[C2_COUNT_RUN_BIT];
            periodic_flag_d = 1'b0;
        end
        if (period_evt) begin
            periodic_flag_d = 1'b1;
        end
        if (div_reset) begin
            div_d = '0;
        end else if (tick && osc_run_q) begin
            div_d = div_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // calendar counters and alarm bytes
    // ----------------------------------------------------------------
    always_comb begin
        logic c;
        logic [7:0] nv;
        cal_d = cal_q;
        alarm_d = alarm_q;
        c = 1'b0;
        nv = 8'h00;
        if (alarm_wr && alarm_sel <= F_YEAR) begin
            alarm_d[alarm_sel] = alarm_wdata;
        end
        if (half_minute_round) begin
            c = (cal_q[F_SEC] >= ROUND_UP_SEC);
            cal_d[F_SEC] = ZERO_RESET;
        end else if (sec_tick && run_q) begin
            c = wrap_inc(cal_q[F_SEC], SEC_MAX, ZERO_RESET, nv);
            cal_d[F_SEC] = nv;
        end
        if (c) begin
            c = wrap_inc(cal_q[F_MIN], MIN_MAX, ZERO_RESET, nv);
            cal_d[F_MIN] = nv;
        end
        if (c) begin
            c = wrap_inc(cal_q[F_HOUR], HOUR_MAX, ZERO_RESET, nv);
            cal_d[F_HOUR] = nv;
        end
        if (c) begin
            void'(wrap_inc(cal_q[F_WDAY], WDAY_MAX, ZERO_RESET, nv));
            cal_d[F_WDAY] = nv;
            c = wrap_inc(cal_q[F_DATE], month_days(cal_q[F_MON], cal_q[F_YEAR]), ONE_RESET, nv);
            cal_d[F_DATE] = nv;
        end
        if (c) begin
            c = wrap_inc(cal_q[F_MON], MON_MAX, ONE_RESET, nv);
            cal_d[F_MON] = nv;
        end
        if (c) begin
            void'(wrap_inc(cal_q[F_YEAR], YEAR_MAX, ZERO_RESET, nv));
            cal_d[F_YEAR] = nv;
        end
        if (time_wr && time_sel <= F_YEAR) begin
            cal_d[time_sel] = time_wdata;
        end
    end

    // registers of all state groups except the count-clock synchroniser
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aie_q <= 1'b0;
            alarm_flag_q <= 1'b0;
            periodic_flag_q <= 1'b0;
            sel_q <= SEL_NONE;
            osc_run_q <= C2_RESET[C2_OSC_RUN_BIT];
            run_q <= C2_RESET[C2_COUNT_RUN_BIT];
            div_q <= '0;
            match_prev_q <= 1'b0;
            alarm_q <= {NUM_FIELDS{ALARM_RESET}};
            cal_q <= {ZERO_RESET, ONE_RESET, ONE_RESET, {4{ZERO_RESET}}};
        end else if (ce) begin
            aie_q <= aie_d;
            alarm_flag_q <= alarm_flag_d;
            periodic_flag_q <= periodic_flag_d;
            sel_q <= sel_d;
            osc_run_q <= osc_run_d;
            run_q <= run_d;
            div_q <= div_d;
            match_prev_q <= match;
            alarm_q <= alarm_d;
            cal_q <= cal_d;
        end
    end
    alarm_compare #(
        .FIELDS(NUM_FIELDS)
    ) u_alarm_compare (
        .alarm_value(alarm_q),
        .counter_value(cal_q),
        .match(match)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign clock_control_one = {4'h0, aie_q, 2'h0, alarm_flag_q};
    assign clock_control_two = {periodic_flag_q, sel_q, osc_run_q, 1'b0, 1'b0, run_q};
    assign clock_control_three = {alarm_q[F_YEAR][ALARM_ENABLE_BIT], 7'h00};
    assign seconds_counter = cal_q[F_SEC];
    assign minutes_counter = cal_q[F_MIN];
    assign hours_counter = cal_q[F_HOUR];
    assign weekday_counter = cal_q[F_WDAY];
    assign date_counter = cal_q[F_DATE];
    assign month_counter = cal_q[F_MON];
    assign year_counter = cal_q[F_YEAR];
    // request levels follow flag and enable
    assign alarm_irq = alarm_flag_q && aie_q;
    assign periodic_irq = periodic_flag_q && (sel_q != SEL_NONE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    chk_alarm_flag_set: assert property (ce && match_rise |=> alarm_flag_q)
        else $error("alarm flag not set on match");
    chk_alarm_irq_raise: assert property (ce && match_rise && aie_q && !ctrl1_wr |=> alarm_irq)
        else $error("alarm request missing");
    chk_alarm_flag_clear: assert property (ce && ctrl1_wr && !ctrl1_wdata[0] && !match_rise
                                           |=> !alarm_flag_q && !alarm_irq)
        else $error("alarm flag not cleared");
    chk_alarm_needs_enable: assert property (match |-> (alarm_q & {NUM_FIELDS{8'h80}}) != '0)
        else $error("alarm matched with no field enabled");
    chk_periodic_set: assert property (ce && period_evt |=> periodic_flag_q)
        else $error("periodic flag not set");
    chk_periodic_select_clr: assert property (ce && ctrl2_wr && !period_evt
                                              |=> !periodic_flag_q)
        else $error("periodic flag survived select write");
    chk_periodic_none: assert property (sel_q == SEL_NONE |-> !period_evt ##1 !periodic_irq)
        else $error("periodic event with none selected");
    chk_round_low: assert property (ce && half_minute_round && cal_q[F_SEC] < ROUND_UP_SEC && !time_wr
                                    |=> cal_q[F_SEC] == 8'h00 &&
                                        cal_q[F_MIN] == $past(cal_q[F_MIN]) && div_q == '0)
        else $error("rounding down failed");
    chk_round_high: assert property (ce && half_minute_round && cal_q[F_SEC] >= ROUND_UP_SEC && !time_wr &&
                                     cal_q[F_MIN] < MIN_MAX
                                     |=> cal_q[F_MIN] == $past(cal_q[F_MIN]) + 8'h01)
        else $error("rounding up failed");
    chk_hold_stopped: assert property (ce && !run_q && !time_wr && !half_minute_round
                                       |=> cal_q == $past(cal_q))
        else $error("calendar moved while stopped");
    chk_divider_frozen: assert property (ce && !osc_run_q && !div_reset
                                         |=> div_q == $past(div_q))
        else $error("divider moved with oscillator off");

endmodule // rtc_core

`default_nettype wire

// [verilog/rtc_pkg.sv]
/*
 * constants shared by the calendar clock: control bit positions, reset values,
 * calendar field indices and limits, divider taps.
 * assumes a 32.768 kHz count clock sampled by the 125 MHz system clock.
 */
package rtc_pkg;

    // ----------------------------------------------------------------
    // clock_control_one bit positions
    // ----------------------------------------------------------------
    localparam int C1_ALARM_IRQ_ENABLE_BIT = 3;
    localparam int C1_ALARM_FLAG_BIT = 0;

    // ----------------------------------------------------------------
    // clock_control_two bit positions and reset value
    // ----------------------------------------------------------------
    localparam int C2_PERIODIC_FLAG_BIT = 7;
    localparam int C2_SELECT_LSB = 4;
    localparam int C2_SELECT_MSB = 6;
    localparam int C2_OSC_RUN_BIT = 3;
    localparam int C2_ROUND_BIT = 2;
    localparam int C2_DIV_RESET_BIT = 1;
    localparam int C2_COUNT_RUN_BIT = 0;
    localparam logic [7:0] C2_RESET = 8'h09;

    // ----------------------------------------------------------------
    // alarm compare enable position, alarm reset value
    // ----------------------------------------------------------------
    localparam int ALARM_ENABLE_BIT = 7;
    localparam logic [7:0] ALARM_RESET = 8'h00;

    // ----------------------------------------------------------------
    // calendar field indices, limits and reset values
    // ----------------------------------------------------------------
    localparam int NUM_FIELDS = 7;
    localparam logic [2:0] F_SEC = 3'h0;
    localparam logic [2:0] F_MIN = 3'h1;
    localparam logic [2:0] F_HOUR = 3'h2;
    localparam logic [2:0] F_WDAY = 3'h3;
    localparam logic [2:0] F_DATE = 3'h4;
    localparam logic [2:0] F_MON = 3'h5;
    localparam logic [2:0] F_YEAR = 3'h6;
    localparam logic [7:0] SEC_MAX = 8'h3b;
    localparam logic [7:0] MIN_MAX = 8'h3b;
    localparam logic [7:0] HOUR_MAX = 8'h17;
    localparam logic [7:0] WDAY_MAX = 8'h06;
    localparam logic [7:0] MON_MAX = 8'h0c;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] ROUND_UP_SEC = 8'h1e;
    localparam logic [7:0] ZERO_RESET = 8'h00;
    localparam logic [7:0] ONE_RESET = 8'h01;

    // ----------------------------------------------------------------
    // divider: count-clock ticks, 65536 ticks span two seconds
    // ----------------------------------------------------------------
    localparam int DIV_WIDTH = 16;
    localparam int SECOND_TAP = 15;
    localparam logic [2:0] SEL_NONE = 3'h0;

endpackage
